// ==== verilog/spi_cbuf_pkg.sv ====
// constants, register map and types for the circular-buffer serial port
// Function
// RL1: transmit flush drops pending bytes, output pointer jumps to transmit pointer, count zero
// RL2: receive flush drops unread bytes, read pointer jumps to input pointer, count zero
// RL3: transmit pending count and unread receive count are both readable
// RL4: head pointer write also loads tail pointer and lower buffer boundary
// RL5: tail pointer write sets upper boundary, tail then reverts to head value
// RL6: head and tail equal before any transfer means an empty buffer
// RL7: boundaries stay fixed while head and tail pointers move
// RL8: transmit flush leaves head pointer unchanged
// RL9: receive flush changes neither head nor tail pointer
// RL10: data write stores byte at head, advances head, increments transmit count
// RL11: received byte shows in data register, bumps receive count; reads advance tail
// RL12: transmit flag set while transmit count is below transmit trigger level
// RL13: receive flag set while receive count exceeds receive trigger level
// RL14: either flag raises the shared auxiliary interrupt output
// RL15: both flags are separate bits of the auxiliary status register
// RL16: software clears each flag after servicing it
// RL17: control holds enable, master, polarity, phase, order, divisor; clock is divided
// RL18: transmit and receive trigger levels are programmed independently
// RL19: receive count write with flush bit flushes; low bits set receive level
// RL20: transmit count write with flush bit flushes; low bits set transmit level
// RL21: receive count register has flush in bit 7, unread count in bits 6:0
// RL22: transmit count decrements when a byte has been shifted out
// RL23: each data read returns the oldest unread byte and moves on
// RL24: pointers wrap from upper boundary back to lower boundary
package spi_cbuf_pkg;
  localparam int PTR_W = 8;
  localparam int CNT_W = 7;
  localparam int BUF_DEPTH = 256;

  // register index = haddr[4:2]
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_TXCNT  = 3'h1;
  localparam logic [2:0] REG_RXCNT  = 3'h2;
  localparam logic [2:0] REG_HEAD   = 3'h3;
  localparam logic [2:0] REG_TAIL   = 3'h4;
  localparam logic [2:0] REG_DATA   = 3'h5;
  localparam logic [2:0] REG_AUX    = 3'h6;
  localparam logic [2:0] REG_BOUNDS = 3'h7;

  localparam int FLUSH_BIT  = 7;
  localparam int AUX_TX_BIT = 3;
  localparam int AUX_RX_BIT = 2;

  localparam logic [7:0]       CTRL_RST  = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST   = 8'h00;
  localparam logic [PTR_W-1:0] UPPER_RST = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_MAX   = 7'h7F;
  localparam logic [CNT_W-1:0] LEVEL_RST = 7'h00;
  localparam logic [7:0]       IDLE_FILL = 8'hFF;
  localparam logic [4:0]       LAST_EDGE = 5'h0F;

  // serial_control_reg layout, msb first
  typedef struct packed {
    logic       serialPortOn;
    logic       masterSelect;
    logic       cpol;
    logic       cpha;
    logic       lsbFirst;
    logic [2:0] divSel;
  } ctrl_t;

  typedef enum logic {SH_IDLE, SH_RUN} shift_state_t;
endpackage

// ==== verilog/spi_cbuf_dma.sv ====
// serial port with a shared circular byte buffer, ahb-lite register slave
`timescale 1ns/100ps
module spi_cbuf_dma
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        sclkIn,
  output logic             sclkOut,
  output logic             sclkOe,
  input  wire logic        mosiIn,
  output logic             mosiOut,
  output logic             mosiOe,
  input  wire logic        misoIn,
  output logic             misoOut,
  output logic             misoOe,
  input  wire logic        ssIn,
  output logic             ssOut,
  output logic             ssOe,
  output logic             auxiliaryInterrupt
);
  import spi_cbuf_pkg::*;
  ctrl_t              ctrl;
  logic [CNT_W-1:0]   txCount;
  logic [CNT_W-1:0]   rxCount;
  logic [CNT_W-1:0]   txLevel;
  logic [CNT_W-1:0]   rxLevel;
  logic [PTR_W-1:0]   headPtr;
  logic [PTR_W-1:0]   tailPtr;
  logic [PTR_W-1:0]   lowerBound;
  logic [PTR_W-1:0]   upperBound;
  logic [PTR_W-1:0]   shiftPtr;
  logic [PTR_W-1:0]   rdPtr;
  logic [7:0]         mem [BUF_DEPTH];
  logic [7:0]         lastRx;
  logic               txFlag;
  logic               rxFlag;
  logic               wrPend;
  logic               rdPend;
  logic               addrOk;
  logic [2:0]         regSel;
  shift_state_t       shState;
  logic [7:0]         txSh;
  logic [7:0]         rxSh;
  logic [4:0]         edgeCnt;
  logic [7:0]         halfCnt;
  logic               sclkPrev;
  logic               rxDone;
  logic [7:0]         next_txSh;
  logic [7:0]         next_rxSh;
  logic [7:0]         readVal;
  function automatic logic [PTR_W-1:0] wrapInc(input logic [PTR_W-1:0] p);
    return (p == upperBound) ? lowerBound : p + 8'h01; // RL24
  endfunction
  // ahb-lite: writes take effect in the data phase, reads add one wait state
  logic accept;
  assign accept = hsel & hready & htrans[1];
  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      wrPend    <= 1'b0;
      rdPend    <= 1'b0;
      addrOk    <= 1'b0;
      regSel    <= REG_CTRL;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wrPend    <= accept & hwrite;
      rdPend    <= accept & ~hwrite;
      hreadyout <= ~(accept & ~hwrite);
      if (accept)
      begin
        regSel <= haddr[4:2];
        addrOk <= (haddr[31:5] == 27'h000_0000) && (haddr[1:0] == 2'h0);
      end
    end
  logic wrCtrl, wrTxCnt, wrRxCnt, wrHead, wrTail, wrData, wrAux, popData;
  logic tx_discard, rx_discard;
  assign wrCtrl  = wrPend & addrOk & (regSel == REG_CTRL);
  assign wrTxCnt = wrPend & addrOk & (regSel == REG_TXCNT);
  assign wrRxCnt = wrPend & addrOk & (regSel == REG_RXCNT);
  assign wrHead  = wrPend & addrOk & (regSel == REG_HEAD);
  assign wrTail  = wrPend & addrOk & (regSel == REG_TAIL);
  assign wrData  = wrPend & addrOk & (regSel == REG_DATA);
  assign wrAux   = wrPend & addrOk & (regSel == REG_AUX);
  assign tx_discard = wrTxCnt & hwdata[FLUSH_BIT]; // RL20
  assign rx_discard = wrRxCnt & hwdata[FLUSH_BIT]; // RL19
  assign popData = rdPend & addrOk & (regSel == REG_DATA) & (rxCount != 7'h00);
  always_comb
  begin
    readVal = 8'h00;
    case (regSel)
      REG_CTRL:  readVal = ctrl;
      REG_TXCNT: readVal = {1'b0, txCount}; // RL3
      REG_RXCNT: readVal = {1'b0, rxCount}; // RL21
      REG_HEAD:  readVal = headPtr;
      REG_TAIL:  readVal = tailPtr;
      REG_DATA:  readVal = (rxCount != 7'h00) ? mem[rdPtr] : lastRx; // RL23
      REG_AUX:   readVal = {4'h0, txFlag, rxFlag, 2'h0}; // RL15
      default:   readVal = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
    if (sys_rst)
      hrdata <= 32'h0000_0000;
    else if (rdPend)
      hrdata <= !addrOk ? 32'h0000_0000 :
                (regSel == REG_BOUNDS) ? {16'h0000, upperBound, lowerBound} :
                {24'h00_0000, readVal};
  // control and trigger levels
  always_ff @(posedge core_clk)
    if (sys_rst)
      ctrl <= CTRL_RST;
    else if (wrCtrl)
      ctrl <= hwdata[7:0]; // RL17

  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      txLevel <= LEVEL_RST;
      rxLevel <= LEVEL_RST;
    end
    else
    begin
      if (wrTxCnt)
        txLevel <= hwdata[CNT_W-1:0]; // RL18 RL20
      if (wrRxCnt)
        rxLevel <= hwdata[CNT_W-1:0]; // RL18 RL19
    end
  // buffer boundaries only move on a head or tail register write
  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      lowerBound <= PTR_RST;
      upperBound <= UPPER_RST;
    end
    else
    begin
      if (wrHead)
        lowerBound <= hwdata[PTR_W-1:0]; // RL4 RL7
      if (wrTail)
        upperBound <= hwdata[PTR_W-1:0]; // RL5 RL7
    end
  // head pointer: cpu writes land here
  always_ff @(posedge core_clk)
    if (sys_rst)
      headPtr <= PTR_RST;
    else if (wrHead)
      headPtr <= hwdata[PTR_W-1:0]; // RL4 RL6
    else if (wrData)
      headPtr <= wrapInc(headPtr); // RL10
    else if (rxDone && txCount == 7'h00)
      headPtr <= wrapInc(shiftPtr); // keeps received bytes clear of new writes
  // tail pointer follows processor reads
  always_ff @(posedge core_clk)
    if (sys_rst)
      tailPtr <= PTR_RST;
    else if (wrHead)
      tailPtr <= hwdata[PTR_W-1:0]; // RL4
    else if (wrTail)
      tailPtr <= headPtr; // RL5
    else if (popData)
      tailPtr <= wrapInc(rdPtr); // RL11
  // output/input pointer of the shifter and processor read pointer
  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      shiftPtr <= PTR_RST;
      rdPtr    <= PTR_RST;
    end
    else
    begin
      if (wrHead)
        shiftPtr <= hwdata[PTR_W-1:0];
      else if (tx_discard)
        shiftPtr <= headPtr; // RL1 RL8
      else if (rxDone)
        shiftPtr <= wrapInc(shiftPtr);
      if (wrHead)
        rdPtr <= hwdata[PTR_W-1:0];
      else if (rx_discard)
        rdPtr <= shiftPtr; // RL2 RL9
      else if (popData)
        rdPtr <= wrapInc(rdPtr); // RL23
    end
  // byte counts
  logic txInc, txDec, rxInc;
  assign txInc = wrData & (txCount != CNT_MAX);
  assign txDec = rxDone & (txCount != 7'h00);
  assign rxInc = rxDone & (rxCount != CNT_MAX);
  always_ff @(posedge core_clk)
    if (sys_rst)
      txCount <= 7'h00;
    else if (wrHead || tx_discard)
      txCount <= 7'h00; // RL1
    else
      txCount <= txCount + {6'h00, txInc} - {6'h00, txDec}; // RL10 RL22
  always_ff @(posedge core_clk)
    if (sys_rst)
      rxCount <= 7'h00;
    else if (wrHead || rx_discard)
      rxCount <= 7'h00; // RL2
    else
      rxCount <= rxCount + {6'h00, rxInc} - {6'h00, popData}; // RL11
  always_ff @(posedge core_clk)
  begin
    if (wrData)
      mem[headPtr] <= hwdata[7:0]; // RL10
    if (rxDone)
      mem[shiftPtr] <= next_rxSh;
  end
  always_ff @(posedge core_clk)
    if (sys_rst)
      lastRx <= 8'h00;
    else if (rxDone)
      lastRx <= next_rxSh; // RL11
  // level flags: the set term wins over a software clear in the same cycle
  logic txCond, rxCond;
  assign txCond = ctrl.serialPortOn & (txCount < txLevel);
  assign rxCond = ctrl.serialPortOn & (rxCount > rxLevel);
  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      txFlag             <= 1'b0;
      rxFlag             <= 1'b0;
      auxiliaryInterrupt <= 1'b0;
    end
    else
    begin
      txFlag <= txCond | (txFlag & ~(wrAux & ~hwdata[AUX_TX_BIT])); // RL12 RL16
      rxFlag <= rxCond | (rxFlag & ~(wrAux & ~hwdata[AUX_RX_BIT])); // RL13 RL16
      auxiliaryInterrupt <= txFlag | rxFlag; // RL14
    end
  // serial shifter
  logic tick, sclkEdge, leadEdge, sampleEdge, shiftEdge, inBit, startMaster, startSlave;
  assign tick        = (halfCnt == ((8'h01 << ctrl.divSel) - 8'h01));
  assign sclkEdge    = (shState == SH_RUN) &
                       (ctrl.masterSelect ? tick : (sclkIn != sclkPrev));
  assign leadEdge    = ~edgeCnt[0];
  assign sampleEdge  = sclkEdge & (leadEdge ^ ctrl.cpha);
  assign shiftEdge   = sclkEdge & ~(leadEdge ^ ctrl.cpha) & ~(ctrl.cpha & edgeCnt == 5'h00);
  assign inBit       = ctrl.masterSelect ? misoIn : mosiIn;
  assign startMaster = ctrl.serialPortOn & ctrl.masterSelect & (txCount != 7'h00) & ~tx_discard;
  assign startSlave  = ctrl.serialPortOn & ~ctrl.masterSelect & ~ssIn;
  assign rxDone      = sclkEdge & (edgeCnt == LAST_EDGE) & ~tx_discard & ~wrHead;
  always_comb
  begin
    next_txSh = txSh;
    next_rxSh = rxSh;
    if (shState == SH_IDLE)
      next_txSh = (txCount != 7'h00) ? mem[shiftPtr] : IDLE_FILL;
    else if (shiftEdge)
      next_txSh = ctrl.lsbFirst ? {1'b0, txSh[7:1]} : {txSh[6:0], 1'b0};
    if (sampleEdge)
      next_rxSh = ctrl.lsbFirst ? {inBit, rxSh[7:1]} : {rxSh[6:0], inBit};
  end

  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      shState  <= SH_IDLE;
      edgeCnt  <= 5'h00;
      halfCnt  <= 8'h00;
      txSh     <= 8'h00;
      rxSh     <= 8'h00;
      sclkPrev <= 1'b0;
    end
    else
    begin
      sclkPrev <= sclkIn;
      txSh     <= next_txSh;
      rxSh     <= next_rxSh;
      halfCnt  <= (shState == SH_IDLE || tick) ? 8'h00 : halfCnt + 8'h01; // RL17
      case (shState)
        SH_IDLE:
        begin
          edgeCnt <= 5'h00;
          if (startMaster || startSlave)
            shState <= SH_RUN;
        end
        SH_RUN:
        begin
          if (!ctrl.serialPortOn || tx_discard || wrHead || (!ctrl.masterSelect && ssIn))
            shState <= SH_IDLE;
          else if (sclkEdge)
          begin
            edgeCnt <= edgeCnt + 5'h01;
            if (edgeCnt == LAST_EDGE)
              shState <= SH_IDLE; // RL22
          end
        end
        default: shState <= SH_IDLE;
      endcase
    end
  // pins: enables are low while driving
  logic isMaster, isSlaveSel;
  assign isMaster   = ctrl.serialPortOn & ctrl.masterSelect;
  assign isSlaveSel = ctrl.serialPortOn & ~ctrl.masterSelect & ~ssIn;
  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      sclkOut <= 1'b0;
      sclkOe  <= 1'b1;
      mosiOut <= 1'b0;
      mosiOe  <= 1'b1;
      misoOut <= 1'b0;
      misoOe  <= 1'b1;
      ssOut   <= 1'b1;
      ssOe    <= 1'b1;
    end
    else
    begin
      sclkOe  <= ~isMaster;
      mosiOe  <= ~isMaster;
      ssOe    <= ~isMaster;
      misoOe  <= ~isSlaveSel;
      // select falls with the start decision, 1 << divSel clocks ahead of the first edge
      ssOut   <= ~(isMaster & ((shState == SH_RUN) | startMaster));
      sclkOut <= (isMaster && shState == SH_RUN && tick) ? ~sclkOut :
                 (shState == SH_IDLE) ? ctrl.cpol : sclkOut;
      mosiOut <= ctrl.lsbFirst ? next_txSh[0] : next_txSh[7];
      misoOut <= ctrl.lsbFirst ? next_txSh[0] : next_txSh[7];
    end
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_readAccept;
    accept && !hwrite;
  endsequence
  sequence s_waitThenReady;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_flagUp;
    txFlag || rxFlag;
  endsequence
  property p_tx_discard;
    tx_discard && !wrHead |=> txCount == 7'h00 && shiftPtr == $past(headPtr);
  endproperty
  a_tx_discard: assert property (p_tx_discard) else $error("tx flush failed"); // RL1
  property p_rx_discard;
    rx_discard && !wrHead |=> rxCount == 7'h00 && rdPtr == $past(shiftPtr);
  endproperty
  a_rx_discard: assert property (p_rx_discard) else $error("rx flush failed"); // RL2
  property p_headWrite;
    wrHead |=> headPtr == $past(hwdata[7:0]) && tailPtr == headPtr && lowerBound == headPtr;
  endproperty
  a_headWrite: assert property (p_headWrite) else $error("head write failed"); // RL4
  property p_tailWrite;
    wrTail |=> upperBound == $past(hwdata[7:0]) && tailPtr == $past(headPtr);
  endproperty
  a_tailWrite: assert property (p_tailWrite) else $error("tail write failed"); // RL5
  property p_txFlushKeepsHead;
    tx_discard && !rxDone |=> headPtr == $past(headPtr);
  endproperty
  a_txFlushKeepsHead: assert property (p_txFlushKeepsHead) else $error("head moved"); // RL8
  property p_rxFlushKeeps;
    rx_discard && !rxDone |=> $stable(headPtr) && $stable(tailPtr);
  endproperty
  a_rxFlushKeeps: assert property (p_rxFlushKeeps) else $error("pointers moved"); // RL9
  property p_dataWrite;
    wrData && !rxDone && txCount != CNT_MAX && headPtr != upperBound
      |=> txCount == $past(txCount) + 7'h01 && headPtr == $past(headPtr) + 8'h01;
  endproperty
  a_dataWrite: assert property (p_dataWrite) else $error("data write failed"); // RL10
  property p_wrap;
    wrData && headPtr == upperBound |=> headPtr == lowerBound;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap"); // RL24
  property p_txShifted;
    rxDone && txCount != 7'h00 && !wrData |=> txCount == $past(txCount) - 7'h01;
  endproperty
  a_txShifted: assert property (p_txShifted) else $error("tx count not down"); // RL22
  property p_txFlag;
    txCond |=> txFlag ##1 auxiliaryInterrupt;
  endproperty
  a_txFlag: assert property (p_txFlag) else $error("tx flag missing"); // RL12
  property p_rxFlag;
    rxCond |=> rxFlag;
  endproperty
  a_rxFlag: assert property (p_rxFlag) else $error("rx flag missing"); // RL13
  property p_auxIrq;
    s_flagUp |=> auxiliaryInterrupt;
  endproperty
  a_auxIrq: assert property (p_auxIrq) else $error("aux interrupt missing"); // RL14
  property p_readWait;
    s_readAccept |=> s_waitThenReady;
  endproperty
  a_readWait: assert property (p_readWait) else $error("read timing wrong"); // reads add one wait state
endmodule

// ==== tb/spi_peer_model.sv ====
// serial peer model: mode 0 slave, msb first, canned reply bytes
`timescale 1ns/100ps
module spi_peer_model
(
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic ssN,
  output logic      miso
);
  logic [7:0] replies [0:3] = '{8'hA5, 8'h3C, 8'h96, 8'h0F};
  logic [7:0] got     [0:3];
  logic [7:0] shiftIn  = 8'h00;
  logic [7:0] shiftOut = 8'h00;
  int         bitIdx   = 0;
  int         nOut     = 0;
  int         nGot     = 0;

  initial
    miso = 1'b0;

  always @(negedge ssN)
  begin
    bitIdx = 0;
    shiftOut = replies[nOut % 4];
    miso = shiftOut[7];
  end

  // sample on the leading edge, next byte queued after the eighth bit
  always @(posedge sclk)
  begin
    if (ssN === 1'b0)
    begin
      shiftIn = {shiftIn[6:0], mosi};
      bitIdx = bitIdx + 1;
      if (bitIdx == 8)
      begin
        got[nGot % 4] = shiftIn;
        nGot = nGot + 1;
        nOut = nOut + 1;
        bitIdx = 0;
        shiftOut = replies[nOut % 4];
      end
    end
  end

  // shift out on the trailing edge
  always @(negedge sclk)
  begin
    if (ssN === 1'b0)
      miso = shiftOut[7 - bitIdx];
  end

  // released line: show the inverse of the last level
  always @(posedge ssN)
    miso = ~miso;
endmodule

// ==== tb/spi_circular_buffer_dma_test.sv ====
// self-checking bench for the circular-buffer serial port
`timescale 1ns/100ps
module spi_circular_buffer_dma_test;
  import spi_cbuf_pkg::*;
  localparam int TIME_LIMIT = 20000;
  logic        core_clk;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe, ssOut, ssOe;
  logic        auxiliaryInterrupt;
  logic        peerMiso;
  logic [31:0] scratch;
  int          mismatches = 0;
  int          checksDone = 0;
  int          cycles     = 0;
  wire         sclkW = sclkOe ? 1'b0 : sclkOut;
  wire         mosiW = mosiOe ? 1'b1 : mosiOut;
  wire         ssW   = ssOe ? 1'b1 : ssOut;
  wire         misoW = misoOe ? peerMiso : misoOut;

  spi_cbuf_dma dut_u
  (
    .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .sclkIn(sclkW), .sclkOut, .sclkOe, .mosiIn(mosiW), .mosiOut, .mosiOe,
    .misoIn(misoW), .misoOut, .misoOe, .ssIn(ssW), .ssOut, .ssOe,
    .auxiliaryInterrupt
  );

  spi_peer_model peer_u
  (
    .sclk(sclkW),
    .mosi(mosiW),
    .ssN(ssW),
    .miso(peerMiso)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] regAddr(input logic [2:0] idx);
    return {27'h000_0000, idx, 2'b00};
  endfunction

  task automatic stopTest();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hready is registered, so its value before the edge is what the edge samples
  task automatic waitReady(output logic [31:0] q);
    do
      @(negedge core_clk);
    while (hreadyout !== 1'b1);
    q = hrdata;
    @(posedge core_clk);
  endtask

  task automatic busCycle(input logic wr, input logic [31:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    logic [31:0] unused;
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    waitReady(unused);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitReady(q);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrReg(input logic [2:0] idx, input logic [7:0] d);
    logic [31:0] q;
    busCycle(1'b1, regAddr(idx), {24'h00_0000, d}, q);
  endtask

  task automatic rdAddr(input logic [31:0] a, input logic [15:0] e);
    logic [31:0] q;
    busCycle(1'b0, a, 32'h0000_0000, q);
    chk(q, {16'h0000, e});
  endtask

  task automatic rdReg(input logic [2:0] idx, input logic [15:0] e);
    rdAddr(regAddr(idx), e);
  endtask

  task automatic intChk(input logic e);
    @(negedge core_clk);
    chk({31'h0000_0000, auxiliaryInterrupt}, {31'h0000_0000, e});
    @(posedge core_clk);
  endtask

  task automatic pollRx(input logic [6:0] e);
    logic [31:0] q;
    for (int i = 0; i < 60; i++)
    begin
      busCycle(1'b0, regAddr(REG_RXCNT), 32'h0000_0000, q);
      if (q[6:0] == e)
        break;
    end
    chk(q, {25'h000_0000, e});
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == TIME_LIMIT)
    begin
      mismatches++;
      stopTest();
    end
  end

  initial
  begin
    sys_rst <= 1'b1;
    hsel    <= 1'b0;
    haddr   <= 32'h0000_0000;
    htrans  <= 2'b00;
    hwrite  <= 1'b0;
    hsize   <= 3'b010;
    hwdata  <= 32'h0000_0000;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rdReg(REG_CTRL, 16'h0000);
    rdReg(REG_TXCNT, 16'h0000);
    rdReg(REG_RXCNT, 16'h0000);
    rdReg(REG_BOUNDS, {UPPER_RST, PTR_RST});
    rdReg(REG_AUX, 16'h0000);
    busCycle(1'b1, 32'h0000_0040, 32'h0000_00FF, scratch);
    rdAddr(32'h0000_0040, 16'h0000);
    intChk(1'b0);
    $display("test reset values done");
    wrReg(REG_HEAD, 8'h10);
    rdReg(REG_TAIL, 16'h0010);
    rdReg(REG_BOUNDS, 16'hFF10);
    wrReg(REG_TAIL, 8'h11);
    rdReg(REG_TAIL, 16'h0010);
    rdReg(REG_BOUNDS, 16'h1110);
    wrReg(REG_CTRL, 8'h3F);
    rdReg(REG_CTRL, 16'h003F);
    wrReg(REG_DATA, 8'hAA);
    wrReg(REG_DATA, 8'hBB);
    wrReg(REG_DATA, 8'hCC);
    rdReg(REG_TXCNT, 16'h0003);
    rdReg(REG_HEAD, 16'h0011);
    rdReg(REG_BOUNDS, 16'h1110);
    wrReg(REG_TXCNT, 8'h80);
    rdReg(REG_TXCNT, 16'h0000);
    rdReg(REG_HEAD, 16'h0011);
    $display("test pointers and transmit flush done");
    wrReg(REG_CTRL, 8'h00);
    wrReg(REG_HEAD, 8'h40);
    wrReg(REG_TAIL, 8'h4F);
    wrReg(REG_TXCNT, 8'h00);
    wrReg(REG_RXCNT, 8'h01);
    wrReg(REG_CTRL, 8'hC0);
    wrReg(REG_DATA, 8'h5A);
    wrReg(REG_DATA, 8'hC3);
    pollRx(7'h02);
    rdReg(REG_TXCNT, 16'h0000);
    chk({24'h00_0000, peer_u.got[0]}, 32'h0000_005A);
    chk({24'h00_0000, peer_u.got[1]}, 32'h0000_00C3);
    rdReg(REG_AUX, 16'h0004);
    intChk(1'b1);
    rdReg(REG_DATA, 16'h00A5);
    rdReg(REG_DATA, 16'h003C);
    rdReg(REG_TAIL, 16'h0042);
    rdReg(REG_RXCNT, 16'h0000);
    wrReg(REG_AUX, 8'h00);
    rdReg(REG_AUX, 16'h0000);
    intChk(1'b0);
    $display("test master transfer done");
    wrReg(REG_DATA, 8'h77);
    pollRx(7'h01);
    chk({24'h00_0000, peer_u.got[2]}, 32'h0000_0077);
    rdReg(REG_AUX, 16'h0000);
    wrReg(REG_RXCNT, 8'h80);
    rdReg(REG_RXCNT, 16'h0000);
    rdReg(REG_HEAD, 16'h0043);
    rdReg(REG_TAIL, 16'h0042);
    wrReg(REG_TXCNT, 8'h04);
    rdReg(REG_AUX, 16'h0008);
    wrReg(REG_AUX, 8'h00);
    rdReg(REG_AUX, 16'h0008);
    intChk(1'b1);
    $display("test receive flush and levels done");
    wrReg(REG_CTRL, 8'hC9);
    wrReg(REG_DATA, 8'h12);
    pollRx(7'h01);
    chk({24'h00_0000, peer_u.got[3]}, 32'h0000_0048);
    rdReg(REG_DATA, 16'h00F0);
    $display("test divided lsb-first transfer done");
    stopTest();
  end
endmodule
